// ### legacy_display_routing_decode.sv
// Purpose: Steers legacy display cycles to hub link or graphics; holds the memory clock select.
// Assumes: Inputs are synchronous to clk_sys; the strap is stable across reset release.
// Notes:   A routing answer appears one cycle after a request.
module legacy_display_routing_decode #(
  parameter int RELOCK_CYCLES = legacy_display_routing_pkg::RELOCK_CYCLES
) (
  // Clock and reset
  input  wire logic                                     clk_sys,
  input  wire logic                                     rst,
  // Strap
  input  wire logic [1:0]                               front_bus_frequency_strap,
  // Processor cycle to steer
  input  wire legacy_display_routing_pkg::cycle_req_s   cycle_req,
  output      legacy_display_routing_pkg::cycle_route_s cycle_route,
  // Memory clock control
  output      logic                                     mem_clock_hold,
  output      logic [9:0]                               mem_clock_mhz,
  output      logic [10:0]                              mem_io_clock_mhz,
  output      logic                                     mem_rate_reserved,
  // AXI4-Lite slave
  input  wire logic [7:0]                               s_axi_awaddr,
  input  wire logic                                     s_axi_awvalid,
  output      logic                                     s_axi_awready,
  input  wire logic [31:0]                              s_axi_wdata,
  input  wire logic [3:0]                               s_axi_wstrb,
  input  wire logic                                     s_axi_wvalid,
  output      logic                                     s_axi_wready,
  output      logic [1:0]                               s_axi_bresp,
  output      logic                                     s_axi_bvalid,
  input  wire logic                                     s_axi_bready,
  input  wire logic [7:0]                               s_axi_araddr,
  input  wire logic                                     s_axi_arvalid,
  output      logic                                     s_axi_arready,
  output      logic [31:0]                              s_axi_rdata,
  output      logic [1:0]                               s_axi_rresp,
  output      logic                                     s_axi_rvalid,
  input  wire logic                                     s_axi_rready
);

  if (RELOCK_CYCLES < 1 || RELOCK_CYCLES > 65535) begin : g_bad_relock
    $error("RELOCK_CYCLES out of range");
  end

  typedef enum logic [1:0] {SYNC_IDLE, SYNC_HOLD, SYNC_RELOCK} sync_state_e;

  // Software state
  logic [1:0]  freq_sel;
  logic [1:0]  freq_applied;
  logic        mono_present;
  logic        colour_en;
  logic        isa_en;
  logic [15:0] io_window_base;
  logic [15:0] io_window_limit;
  logic [1:0]  strap;
  logic        strap_taken;
  sync_state_e sync_state;
  logic [15:0] relock_cnt;
  logic        sync_start;

  // Bus slave state
  logic        aw_got;
  logic        w_got;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;
  logic        next_aw_got;
  logic        next_w_got;
  logic        next_bvalid;
  logic        next_rvalid;
  logic        ar_take;

  function automatic legacy_display_routing_pkg::mem_rate_e rate_of(input logic [1:0] bus, input logic [1:0] sel);
    if (bus == legacy_display_routing_pkg::STRAP_LOW && sel == legacy_display_routing_pkg::SEL_LOW) begin
      return legacy_display_routing_pkg::RATE_333;
    end else if (bus == legacy_display_routing_pkg::STRAP_HIGH && sel == legacy_display_routing_pkg::SEL_LOW) begin
      return legacy_display_routing_pkg::RATE_320;
    end else if (bus == legacy_display_routing_pkg::STRAP_HIGH && sel == legacy_display_routing_pkg::SEL_HIGH) begin
      return legacy_display_routing_pkg::RATE_400;
    end
    return legacy_display_routing_pkg::RATE_RESERVED;
  endfunction

  // Monochrome I/O; aliases match as only bits 9:0 count
  function automatic logic is_mono_io(input logic [15:0] a);
    logic [9:0] low;
    low = a[9:0];
    return low == 10'h3b4 || low == 10'h3b5 || low == 10'h3b8 ||
           low == 10'h3b9 || low == 10'h3ba || low == 10'h3bf;
  endfunction

  // Colour display I/O: 3B0h-3BBh and 3C0h-3DFh with aliases
  function automatic logic is_colour_io(input logic [15:0] a);
    logic [9:0] low;
    low = a[9:0];
    return (low >= 10'h3b0 && low <= 10'h3bb) || (low >= 10'h3c0 && low <= 10'h3df);
  endfunction

  function automatic logic is_3bc_block(input logic [15:0] a);
    return a[9:2] == 8'hef;
  endfunction

  function automatic logic in_window(input logic [15:0] a, input logic [15:0] base, input logic [15:0] limit);
    return a >= base && a <= limit;
  endfunction

  // Per-byte I/O classification
  logic [3:0] byte_hub;
  logic [3:0] byte_gfx;
  logic [3:0] byte_legacy;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_byte
      logic [15:0] loc;
      logic        mono;
      logic        colour;
      logic        blk;
      assign loc    = {cycle_req.addr[15:2], 2'(gi)};
      assign mono   = is_mono_io(loc);
      assign colour = is_colour_io(loc);
      assign blk    = is_3bc_block(loc);
      always_comb begin
        byte_hub[gi]    = 1'b0;
        byte_gfx[gi]    = 1'b0;
        byte_legacy[gi] = cycle_req.byte_en[gi] & (mono | colour | blk);
        if (cycle_req.byte_en[gi]) begin
          if (mono && mono_present) begin
            byte_hub[gi] = 1'b1;
          end else if (loc[9:0] == 10'h3bf) begin
            byte_hub[gi] = 1'b1;
          end else if (!colour_en && (colour || blk)) begin
            byte_hub[gi] = 1'b1;
          end else if (colour) begin
            byte_gfx[gi] = 1'b1;
          end else if (blk) begin
            if (in_window(loc, io_window_base, io_window_limit) && !isa_en) begin
              byte_gfx[gi] = 1'b1;
            end else begin
              byte_hub[gi] = 1'b1;
            end
          end else begin
            byte_hub[gi] = 1'b1;
          end
        end
      end
    end
  endgenerate

  // Colour frame buffer A0000h-BFFFFh, mono part B0000h-B7FFFh
  logic mem_colour;
  logic mem_mono;
  assign mem_colour = cycle_req.addr[31:17] == 15'h0005;
  assign mem_mono   = cycle_req.addr[31:15] == 17'h00016;

  // Routing answer, registered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cycle_route <= '0;
    end else begin
      cycle_route.valid <= cycle_req.valid;
      if (cycle_req.is_io) begin
        cycle_route.legacy_hit  <= cycle_req.valid & (|byte_legacy);
        cycle_route.to_hub_link <= cycle_req.valid & ((|byte_hub) | ~(|byte_gfx));
        cycle_route.to_graphics <= cycle_req.valid & ~(|byte_hub) & (|byte_gfx);
      end else begin
        cycle_route.legacy_hit <= cycle_req.valid & mem_colour;
        if (mem_colour && colour_en && !(mem_mono && mono_present)) begin
          cycle_route.to_graphics <= cycle_req.valid;
          cycle_route.to_hub_link <= 1'b0;
        end else begin
          cycle_route.to_graphics <= 1'b0;
          cycle_route.to_hub_link <= cycle_req.valid;
        end
      end
    end
  end

  // Strap is taken on the first clock after reset release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap       <= 2'h0;
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      strap       <= front_bus_frequency_strap;
      strap_taken <= 1'b1;
    end
  end

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      freq_sel        <= legacy_display_routing_pkg::FREQ_SEL_RESET;
      mono_present    <= 1'b0;
      colour_en       <= 1'b0;
      isa_en          <= 1'b0;
      io_window_base  <= legacy_display_routing_pkg::IO_BASE_RESET;
      io_window_limit <= legacy_display_routing_pkg::IO_LIMIT_RESET;
      sync_start      <= 1'b0;
    end else begin
      sync_start <= 1'b0;
      if (do_write) begin
        case (aw_addr_q)
          legacy_display_routing_pkg::OFS_MEM_CLK_LEGACY_CTRL: begin
            if (w_strb_q[1]) begin
              freq_sel <= w_data_q[legacy_display_routing_pkg::FREQ_SEL_LSB +: 2];
            end
            if (w_strb_q[0]) begin
              mono_present <= w_data_q[legacy_display_routing_pkg::MONO_PRES_BIT];
            end
          end
          legacy_display_routing_pkg::OFS_BRIDGE_CONTROL_ONE: begin
            if (w_strb_q[0]) begin
              isa_en    <= w_data_q[legacy_display_routing_pkg::ISA_EN_BIT];
              colour_en <= w_data_q[legacy_display_routing_pkg::COLOUR_EN_BIT];
            end
          end
          legacy_display_routing_pkg::OFS_IO_WINDOW: begin
            if (w_strb_q[0]) io_window_base[7:0]   <= w_data_q[7:0];
            if (w_strb_q[1]) io_window_base[15:8]  <= w_data_q[15:8];
            if (w_strb_q[2]) io_window_limit[7:0]  <= w_data_q[23:16];
            if (w_strb_q[3]) io_window_limit[15:8] <= w_data_q[31:24];
          end
          legacy_display_routing_pkg::OFS_CLOCK_SYNC: begin
            sync_start <= w_strb_q[0] & w_data_q[legacy_display_routing_pkg::SYNC_START_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Clock sync: hold, switch, wait for relock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_state     <= SYNC_IDLE;
      relock_cnt     <= 16'h0000;
      freq_applied   <= legacy_display_routing_pkg::FREQ_SEL_RESET;
      mem_clock_hold <= 1'b0;
    end else begin
      case (sync_state)
        SYNC_IDLE: begin
          if (sync_start) begin
            sync_state     <= SYNC_HOLD;
            mem_clock_hold <= 1'b1;
          end
        end
        SYNC_HOLD: begin
          freq_applied <= freq_sel;
          relock_cnt   <= 16'(RELOCK_CYCLES - 1);
          sync_state   <= SYNC_RELOCK;
        end
        SYNC_RELOCK: begin
          if (relock_cnt == 16'h0000) begin
            sync_state     <= SYNC_IDLE;
            mem_clock_hold <= 1'b0;
          end else begin
            relock_cnt <= relock_cnt - 16'h0001;
          end
        end
        default: begin
          sync_state <= SYNC_IDLE;
        end
      endcase
    end
  end

  // Clock figures follow the taken strap and the applied select, not the written one
  legacy_display_routing_pkg::mem_rate_e rate_now;
  assign rate_now = rate_of(strap, freq_applied);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mem_clock_mhz     <= 10'h000;
      mem_io_clock_mhz  <= 11'h000;
      mem_rate_reserved <= 1'b1;
    end else begin
      mem_rate_reserved <= rate_now == legacy_display_routing_pkg::RATE_RESERVED;
      case (rate_now)
        legacy_display_routing_pkg::RATE_333: begin
          mem_clock_mhz    <= legacy_display_routing_pkg::RATE_333_MHZ;
          mem_io_clock_mhz <= {legacy_display_routing_pkg::RATE_333_MHZ, 1'b0};
        end
        legacy_display_routing_pkg::RATE_320: begin
          mem_clock_mhz    <= legacy_display_routing_pkg::RATE_320_MHZ;
          mem_io_clock_mhz <= {legacy_display_routing_pkg::RATE_320_MHZ, 1'b0};
        end
        legacy_display_routing_pkg::RATE_400: begin
          mem_clock_mhz    <= legacy_display_routing_pkg::RATE_400_MHZ;
          mem_io_clock_mhz <= {legacy_display_routing_pkg::RATE_400_MHZ, 1'b0};
        end
        default: begin
          mem_clock_mhz    <= 10'h000;
          mem_io_clock_mhz <= 11'h000;
        end
      endcase
    end
  end

  // AXI4-Lite write channel
  assign do_write    = aw_got & w_got;
  assign next_aw_got = (aw_got & ~do_write) | (s_axi_awvalid & s_axi_awready);
  assign next_w_got  = (w_got & ~do_write) | (s_axi_wvalid & s_axi_wready);
  assign next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

  function automatic logic mapped(input logic [7:0] a);
    return a == legacy_display_routing_pkg::OFS_MEM_CLK_LEGACY_CTRL ||
           a == legacy_display_routing_pkg::OFS_BRIDGE_CONTROL_ONE ||
           a == legacy_display_routing_pkg::OFS_IO_WINDOW ||
           a == legacy_display_routing_pkg::OFS_CLOCK_SYNC;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= legacy_display_routing_pkg::RESP_OKAY;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      s_axi_bvalid  <= next_bvalid;
      s_axi_awready <= ~next_aw_got & ~next_bvalid;
      s_axi_wready  <= ~next_w_got & ~next_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= mapped(aw_addr_q) ? legacy_display_routing_pkg::RESP_OKAY
                                         : legacy_display_routing_pkg::RESP_SLVERR;
      end
    end
  end

  // AXI4-Lite read channel
  assign ar_take     = s_axi_arvalid & s_axi_arready;
  assign next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= legacy_display_routing_pkg::RESP_OKAY;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rresp <= legacy_display_routing_pkg::RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          legacy_display_routing_pkg::OFS_MEM_CLK_LEGACY_CTRL: begin
            s_axi_rdata[legacy_display_routing_pkg::FREQ_SEL_LSB +: 2] <= freq_sel;
            s_axi_rdata[legacy_display_routing_pkg::MONO_PRES_BIT]     <= mono_present;
          end
          legacy_display_routing_pkg::OFS_BRIDGE_CONTROL_ONE: begin
            s_axi_rdata[legacy_display_routing_pkg::ISA_EN_BIT]    <= isa_en;
            s_axi_rdata[legacy_display_routing_pkg::COLOUR_EN_BIT] <= colour_en;
          end
          legacy_display_routing_pkg::OFS_IO_WINDOW: begin
            s_axi_rdata <= {io_window_limit, io_window_base};
          end
          legacy_display_routing_pkg::OFS_CLOCK_SYNC: begin
            s_axi_rdata[7:0] <= {2'(rate_now), strap, freq_applied, 1'b0, sync_state != SYNC_IDLE};
          end
          default: begin
            s_axi_rresp <= legacy_display_routing_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule

// ### legacy_display_routing_pkg.sv
// Purpose: Shared constants and types for the legacy display routing decoder.
// Assumes: AXI4-Lite register access, one 200 MHz clock, synchronous reset.
// Notes:   Offsets are byte addresses; each register takes one 32-bit word.
//
// How it works
// - Memory rate: strap 01 select 01 is 333, strap 10 select 01 is 320, strap 10 select 10 is 400, else reserved.
// - The frequency select resets to 00.
// - The memory I/O clock is always twice the memory clock.
// - A written select applies only after a clock sync sequence, which software runs after each write.
// - Only processor cycles into legacy display ranges are steered, by mono bit and colour enable.
// - Monochrome resources are memory 0B0000h-0B7FFFh and I/O 3B4h, 3B5h, 3B8h, 3B9h, 3BAh and 3BFh.
// - Monochrome I/O matching ignores address bits 15 to 10, so all aliases match.
// - With the mono bit set, an I/O access touching any monochrome location goes to the hub link whatever else it touches.
// - Colour enable and mono bit both clear send every display reference to the hub link.
// - Colour enable set, mono bit clear: colour references to graphics, 3BFh and aliases to the hub link.
// - Colour enable and mono bit both set: colour references to graphics, monochrome to the hub link.
// - With colour enable clear, I/O 3BCh-3BFh goes to the hub link.
// - Otherwise 3BCh-3BEh is plain I/O: graphics inside the I/O window with ISA enable clear, else hub link.
package legacy_display_routing_pkg;

  // Register byte addresses
  localparam logic [7:0] OFS_MEM_CLK_LEGACY_CTRL = 8'h00;
  localparam logic [7:0] OFS_BRIDGE_CONTROL_ONE  = 8'h04;
  localparam logic [7:0] OFS_IO_WINDOW           = 8'h08;
  localparam logic [7:0] OFS_CLOCK_SYNC          = 8'h0c;

  // Field positions
  localparam int FREQ_SEL_LSB   = 10;
  localparam int MONO_PRES_BIT  = 5;
  localparam int ISA_EN_BIT     = 0;
  localparam int COLOUR_EN_BIT  = 1;
  localparam int LIMIT_LSB      = 16;
  localparam int SYNC_START_BIT = 0;

  // Reset values
  localparam logic [1:0]  FREQ_SEL_RESET  = 2'h0;
  localparam logic [15:0] IO_BASE_RESET   = 16'hffff;
  localparam logic [15:0] IO_LIMIT_RESET  = 16'h0000;

  // Frequency codes
  localparam logic [1:0]  STRAP_LOW       = 2'h1;
  localparam logic [1:0]  STRAP_HIGH      = 2'h2;
  localparam logic [1:0]  SEL_LOW         = 2'h1;
  localparam logic [1:0]  SEL_HIGH        = 2'h2;
  localparam logic [9:0]  RATE_333_MHZ    = 10'h14d;
  localparam logic [9:0]  RATE_320_MHZ    = 10'h140;
  localparam logic [9:0]  RATE_400_MHZ    = 10'h190;

  // Clock relock time after a frequency switch
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int RELOCK_NS       = 1000;
  localparam int RELOCK_CYCLES   = (RELOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {RATE_RESERVED, RATE_333, RATE_320, RATE_400} mem_rate_e;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic [31:0] addr;
    logic [3:0]  byte_en;
  } cycle_req_s;

  typedef struct packed {
    logic valid;
    logic to_graphics;
    logic to_hub_link;
    logic legacy_hit;
  } cycle_route_s;

endpackage

// ### legacy_display_routing_properties.sv
// Purpose: Port-level timing and value checks for the routing decoder.
// Assumes: Bound to every decoder instance.
// Notes:   Hold length and time since reset are counted in helper logic.
module legacy_display_routing_properties #(
  parameter int RELOCK_CYCLES = 4
) (
  // Clock and reset
  input wire logic                                     clk_sys,
  input wire logic                                     rst,
  // Cycle steering
  input wire legacy_display_routing_pkg::cycle_req_s   cycle_req,
  input wire legacy_display_routing_pkg::cycle_route_s cycle_route,
  // Memory clock
  input wire logic                                     mem_clock_hold,
  input wire logic [9:0]                               mem_clock_mhz,
  input wire logic [10:0]                              mem_io_clock_mhz,
  input wire logic                                     mem_rate_reserved
);
  int hold_cnt;
  int up_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys) begin
    if (rst || !mem_clock_hold) begin
      hold_cnt <= 0;
    end else begin
      hold_cnt <= hold_cnt + 1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      up_cnt <= 0;
    end else if (up_cnt < 4) begin
      up_cnt <= up_cnt + 1;
    end
  end
  AST_ROUTE_LATENCY: assert property (cycle_req.valid |=> cycle_route.valid)
    else $error("no route one cycle after request");
  AST_ONE_TARGET: assert property (cycle_route.valid |-> cycle_route.to_graphics != cycle_route.to_hub_link)
    else $error("route target not unique");
  AST_MONO_3BF_HUB: assert property (cycle_req.valid && cycle_req.is_io && cycle_req.addr[9:2] == 8'hef &&
    cycle_req.byte_en[3] |=> cycle_route.to_hub_link && cycle_route.legacy_hit)
    else $error("3BF alias not sent to hub link");
  AST_IO_CLOCK_DOUBLE: assert property (mem_io_clock_mhz == {mem_clock_mhz, 1'b0})
    else $error("io clock not twice memory clock");
  AST_RATE_VALUES: assert property (mem_clock_mhz inside {10'h0, 10'h14d, 10'h140, 10'h190})
    else $error("memory clock rate not a table value");
  AST_RESERVED_ZERO: assert property (up_cnt == 4 && !mem_clock_hold |->
    mem_rate_reserved == (mem_clock_mhz == 10'h0))
    else $error("reserved flag disagrees with rate");
  AST_HOLD_LENGTH: assert property ($fell(mem_clock_hold) |-> hold_cnt == RELOCK_CYCLES + 1)
    else $error("sync hold length wrong");
  AST_CLOCK_ONLY_IN_SYNC: assert property (up_cnt == 4 && !$stable(mem_clock_mhz) |-> $past(mem_clock_hold))
    else $error("memory clock changed outside sync");
endmodule

bind legacy_display_routing_decode legacy_display_routing_properties #(.RELOCK_CYCLES(RELOCK_CYCLES)) u_props (
  .clk_sys, .rst, .cycle_req, .cycle_route, .mem_clock_hold, .mem_clock_mhz, .mem_io_clock_mhz, .mem_rate_reserved
);

// ### cpu_cycle_source.sv
// Purpose: Processor side offering one steered cycle per clock on request.
// Assumes: issue and its qualifiers change just after a rising edge.
// Notes:   Idle address lines show the inverse of the last address.
module cpu_cycle_source (
  // Clock
  input  wire logic                                   clk_sys,
  // Request from the bench
  input  wire logic                                   issue,
  input  wire logic                                   is_io,
  input  wire logic [31:0]                            addr,
  input  wire logic [3:0]                             byte_en,
  // Cycle to the decoder
  output      legacy_display_routing_pkg::cycle_req_s cycle_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_addr = 32'h0;
  always_ff @(posedge clk_sys) begin
    if (issue) begin
      last_addr <= addr;
    end
  end
  always_comb begin
    cycle_req.valid   = issue;
    cycle_req.is_io   = is_io;
    cycle_req.addr    = issue ? addr : ~last_addr;
    cycle_req.byte_en = byte_en;
  end
endmodule

// ### legacy_display_routing_decode_bench.sv
// Purpose: Self-checking bench for the legacy display routing decoder.
// Assumes: Relock count shortened to 4; strap steady through each reset.
// Notes:   Routes and register answers are compared with a bench model.
module legacy_display_routing_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  strap = 2'h0;
  logic        issue = 1'b0;
  logic        is_io = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [3:0]  byte_en = 4'h1;
  legacy_display_routing_pkg::cycle_req_s   cycle_req;
  legacy_display_routing_pkg::cycle_route_s cycle_route;
  logic        mem_clock_hold, mem_rate_reserved;
  logic [9:0]  mem_clock_mhz;
  logic [10:0] mem_io_clock_mhz;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          error_cnt = 0;
  int          check_count = 0;
  logic [31:0] seed = 32'h860e;
  int          exp_q[$];
  int          colour, mono, isa, base, limit;

  legacy_display_routing_decode #(.RELOCK_CYCLES(4)) DUT (
    .clk_sys, .rst, .front_bus_frequency_strap(strap), .cycle_req, .cycle_route, .mem_clock_hold, .mem_clock_mhz,
    .mem_io_clock_mhz, .mem_rate_reserved, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  cpu_cycle_source u_cpu (.clk_sys, .issue, .is_io, .addr, .byte_en, .cycle_req);

  always #2.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // 1 when the whole cycle goes to graphics
  function automatic int gfx_exp(logic io, logic [31:0] a, logic [3:0] be);
    int g, h, t;
    logic [15:0] p;
    g = 0;
    h = 0;
    if (!io) begin
      return (a >= 32'hb0000 && a <= 32'hb7fff) ? (colour && !mono) : colour;
    end
    for (int b = 0; b < 4; b++) begin
      p = {a[15:2], 2'(b)};
      if (p[9:0] inside {10'h3b4, 10'h3b5, 10'h3b8, 10'h3b9, 10'h3ba, 10'h3bf}) begin
        t = colour && !mono && p[9:0] != 10'h3bf;
      end else if (p[9:0] inside {[10'h3bc:10'h3be]}) begin
        t = colour && !isa && p >= base && p <= limit;
      end else begin
        t = colour && p[9:0] inside {[10'h3b0:10'h3bb], [10'h3c0:10'h3df]};
      end
      g = g | (be[b] && t);
      h = h | (be[b] && !t);
    end
    return g && !h;
  endfunction

  task automatic fail(string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask

  task automatic chk_val(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
  endtask

  task automatic chk_route(logic [2:0] got, int e);
    check_count++;
    if (e > 1 || got !== {e[0], ~e[0], 1'b1}) fail("route mismatch");
  endtask

  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge clk_sys);
      aw_ok |= s_axi_awvalid && s_axi_awready;
      w_ok |= s_axi_wvalid && s_axi_wready;
      @(posedge clk_sys);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
    chk_val(32'(s_axi_bresp), 32'(er));
    @(posedge clk_sys);
  endtask

  task automatic rd_chk(logic [7:0] a, logic [31:0] exp, logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk_sys); while (s_axi_arready !== 1'b1);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
    chk_val(s_axi_rdata, exp);
    chk_val(32'(s_axi_rresp), 32'(er));
    @(posedge clk_sys);
  endtask

  task automatic wait_hold(logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (mem_clock_hold !== v && n < 50);
    chk_val(32'(mem_clock_hold), 32'(v));
  endtask

  task automatic final_report();
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(negedge clk_sys) begin
    if (cycle_route.valid === 1'b1) chk_route(cycle_route[2:0], exp_q.size() ? exp_q.pop_front() : 2);
  end

  initial begin
    logic [31:0] r;
    logic [31:0] a;
    int m;
    for (int f = 0; f < 4; f++) begin
      for (int s = 0; s < 4; s++) begin
        strap <= 2'(f);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rd_chk(8'h00, 32'h0, 2'h0);
        axi_wr(8'h00, 32'(s) << 10, 2'h0);
        rd_chk(8'h00, 32'(s) << 10, 2'h0);
        rd_chk(8'h0c, 32'(f) << 4, 2'h0);
        axi_wr(8'h0c, 32'h1, 2'h0);
        wait_hold(1'b1);
        wait_hold(1'b0);
        m = (f == 1 && s == 1) ? 333 : (f == 2 && s == 1) ? 320 : (f == 2 && s == 2) ? 400 : 0;
        chk_val(32'(mem_clock_mhz), 32'(m));
        chk_val(32'(mem_io_clock_mhz), 32'(2 * m));
        chk_val(32'(mem_rate_reserved), 32'(m == 0));
        @(posedge clk_sys);
        rd_chk(8'h0c, 32'((m == 0 ? 0 : m == 333 ? 1 : m == 320 ? 2 : 3) << 6 | f << 4 | s << 2), 2'h0);
      end
    end
    axi_wr(8'h10, 32'hffffffff, 2'h2);
    rd_chk(8'h10, 32'h0, 2'h2);
    for (int k = 0; k < 5; k++) begin
      colour = k > 0;
      mono = k == 2;
      isa = k == 3;
      base = k == 4 ? 16'h3bc : 16'h0;
      limit = k == 4 ? 16'h3bd : 16'hffff;
      axi_wr(8'h04, 32'(colour * 2 + isa), 2'h0);
      axi_wr(8'h00, 32'(mono) << 5, 2'h0);
      axi_wr(8'h08, 32'(limit << 16 | base), 2'h0);
      repeat (40) begin
        r = rnd();
        a = r[0] ? {16'h0, r[15:10], 8'(8'hec + r[23:16] % 8'h0c), r[25:24]} : {12'h0, 3'h5, r[16:0]};
        issue <= 1'b1;
        is_io <= r[0];
        addr <= a;
        byte_en <= r[29:26] != 4'h0 ? r[29:26] : 4'h8;
        exp_q.push_back(gfx_exp(r[0], a, r[29:26] != 4'h0 ? r[29:26] : 4'h8));
        @(posedge clk_sys);
      end
      issue <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk_val(32'(exp_q.size()), 32'h0);
    end
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail("watchdog expired");
    final_report();
  end
endmodule
